/* File: verilog/acd_conv_ctrl.sv */
// converter control: registers, successive-approximation sequencer, done request
//
// Notes on behaviour
// - writing one to the start flag begins converting the selected channel
// - at conversion end load result and clear start flag together
// - start flag bit 7 reads one while busy; writing zero aborts
// - conversion period runs from flag set to flag cleared at completion
// - result holds eight bits, unchanged until the next conversion starts
// - result readable any time; value during conversion is undefined
// - reset leaves the result register untouched
// - mode bit 7 picks period: 62 cycles when zero, 31 when one
// - mode bits 2..0 pick channel 0 to 7, default channel 0
// - mode resets to 78h; bits 6..3 read one, ignore writes
// - start register bits 6..0 read one and ignore writes
// - pin select register: one bit per pin, one means analog input
// - pin select register is write-only and resets to all zeros
// - an interrupt request is raised on every conversion completion
// - completion sets the done request flag in the request register
// - interrupt reaches the processor only when its enable bit is one
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module acd_conv_ctrl
  import acd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [`ACD_AXI_ADDR_W-1:0] s_axil_awaddr_i,
  input wire logic s_axil_awvalid_i,
  output logic s_axil_awready_o,
  input wire logic [31:0] s_axil_wdata_i,
  input wire logic [3:0] s_axil_wstrb_i,
  input wire logic s_axil_wvalid_i,
  output logic s_axil_wready_o,
  output logic [1:0] s_axil_bresp_o,
  output logic s_axil_bvalid_o,
  input wire logic s_axil_bready_i,
  input wire logic [`ACD_AXI_ADDR_W-1:0] s_axil_araddr_i,
  input wire logic s_axil_arvalid_i,
  output logic s_axil_arready_o,
  output logic [31:0] s_axil_rdata_o,
  output logic [1:0] s_axil_rresp_o,
  output logic s_axil_rvalid_o,
  input wire logic s_axil_rready_i,
  input wire logic cmp_above_i,
  output logic [2:0] chan_sel_o,
  output logic sample_hold_o,
  output logic [7:0] ladder_code_o,
  output logic [7:0] pin_analog_en_o,
  output logic conv_busy_o,
  output logic irq_o
);

  import acd_pkg::*;

  // ****************************************************************
  // timing
  // ****************************************************************

  // the sample window takes whatever the eight trials leave of the period
  localparam int TRIALS = 8;
  localparam int SAMPLE_SLOW = `ACD_PERIOD_SLOW - TRIALS * `ACD_TRIAL_SLOW;
  localparam int SAMPLE_FAST = `ACD_PERIOD_FAST - TRIALS * `ACD_TRIAL_FAST;
  localparam logic [5:0] SAMPLE_SLOW_C = 6'(SAMPLE_SLOW - 1);
  localparam logic [5:0] SAMPLE_FAST_C = 6'(SAMPLE_FAST - 1);
  localparam logic [5:0] TRIAL_SLOW_C = 6'(`ACD_TRIAL_SLOW - 1);
  localparam logic [5:0] TRIAL_FAST_C = 6'(`ACD_TRIAL_FAST - 1);

  // ****************************************************************
  // declarations
  // ****************************************************************

  acd_reg_req_s req;
  logic [7:0] rd_data;
  logic rd_err;
  logic wr_err;
  logic cmp_sync;

  // software visible state
  logic speed_ff;
  logic [2:0] chan_ff;
  logic start_flag_ff;
  logic [7:0] result_ff;
  logic [7:0] pinsel_ff;
  logic done_req_ff;
  logic done_en_ff;

  // sequencer state
  acd_state_e state_ff;
  logic [5:0] cnt_ff;
  logic [2:0] bit_ff;
  logic [7:0] sar_ff;
  logic fast_ff;

  // output flops
  logic [2:0] chan_out_ff;
  logic sample_out_ff;
  logic [7:0] pin_out_ff;
  logic busy_out_ff;
  logic irq_out_ff;

  // ****************************************************************
  // bus front end and comparator synchroniser
  // ****************************************************************

  acd_axil_slave u_slave (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .s_axil_awaddr_i(s_axil_awaddr_i),
    .s_axil_awvalid_i(s_axil_awvalid_i),
    .s_axil_awready_o(s_axil_awready_o),
    .s_axil_wdata_i(s_axil_wdata_i),
    .s_axil_wstrb_i(s_axil_wstrb_i),
    .s_axil_wvalid_i(s_axil_wvalid_i),
    .s_axil_wready_o(s_axil_wready_o),
    .s_axil_bresp_o(s_axil_bresp_o),
    .s_axil_bvalid_o(s_axil_bvalid_o),
    .s_axil_bready_i(s_axil_bready_i),
    .s_axil_araddr_i(s_axil_araddr_i),
    .s_axil_arvalid_i(s_axil_arvalid_i),
    .s_axil_arready_o(s_axil_arready_o),
    .s_axil_rdata_o(s_axil_rdata_o),
    .s_axil_rresp_o(s_axil_rresp_o),
    .s_axil_rvalid_o(s_axil_rvalid_o),
    .s_axil_rready_i(s_axil_rready_i),
    .req_o(req),
    .wr_err_i(wr_err),
    .rd_data_i(rd_data),
    .rd_err_i(rd_err)
  );

  // comparator is analog, so it is treated as asynchronous
  acd_sync2 #(
    .W(1)
  ) u_cmp_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(cmp_above_i),
    .q_o(cmp_sync)
  );

  // ****************************************************************
  // write decode
  // ****************************************************************

  // a write without byte lane 0 stores nothing but still answers okay
  wire wr_go = req.wr & req.wr_lane0;
  wire wr_mode = wr_go & (req.wr_idx == `ACD_IDX_MODE);
  wire wr_start = wr_go & (req.wr_idx == `ACD_IDX_START);
  wire wr_pinsel = wr_go & (req.wr_idx == `ACD_IDX_PINSEL);
  wire wr_req = wr_go & (req.wr_idx == `ACD_IDX_IRQ_REQ);
  wire wr_en = wr_go & (req.wr_idx == `ACD_IDX_IRQ_EN);
  wire wr_flag = req.wdata[`ACD_START_FLAG_BIT];

  // result is read-only, so a write there is refused
  wire wr_known = (req.wr_idx == `ACD_IDX_MODE) | (req.wr_idx == `ACD_IDX_START) |
                  (req.wr_idx == `ACD_IDX_PINSEL) | (req.wr_idx == `ACD_IDX_IRQ_REQ) |
                  (req.wr_idx == `ACD_IDX_IRQ_EN);
  assign wr_err = ~wr_known;

  // start only from idle; a one written while busy changes nothing
  wire start_go = wr_start & wr_flag & ~start_flag_ff;
  wire abort_go = wr_start & ~wr_flag & start_flag_ff;

  // ****************************************************************
  // sequencer decode
  // ****************************************************************

  wire cnt_end = (cnt_ff == 6'd0);
  wire [5:0] trial_len = fast_ff ? TRIAL_FAST_C : TRIAL_SLOW_C;
  wire in_sample = (state_ff == ACD_ST_SAMPLE);
  wire in_trial = (state_ff == ACD_ST_TRIAL);
  wire sample_end = in_sample & cnt_end;
  wire trial_end = in_trial & cnt_end;
  wire last_trial = trial_end & (bit_ff == 3'd0);
  // abort in the very cycle of completion wins: no result, no request
  wire conv_done = last_trial & ~abort_go;

  // the bit under test is dropped when the input sits below the ladder
  wire [7:0] bit_mask = 8'h01 << bit_ff;
  wire [7:0] sar_kept = cmp_sync ? sar_ff : (sar_ff & ~bit_mask);
  wire [7:0] sar_next_try = sar_kept | (bit_mask >> 1);

  // ****************************************************************
  // sequencer
  // ****************************************************************

  // sample window, then one trial per bit from the msb
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= ACD_ST_IDLE;
      cnt_ff <= 6'd0;
      bit_ff <= 3'd0;
      sar_ff <= 8'h00;
      fast_ff <= 1'b0;
    end else if (abort_go) begin
      state_ff <= ACD_ST_IDLE;
      cnt_ff <= 6'd0;
    end else begin
      case (state_ff)
        ACD_ST_IDLE: begin
          if (start_go) begin
            // speed is frozen for the whole period
            fast_ff <= speed_ff;
            cnt_ff <= speed_ff ? SAMPLE_FAST_C : SAMPLE_SLOW_C;
            state_ff <= ACD_ST_SAMPLE;
            sar_ff <= 8'h00;
          end
        end
        ACD_ST_SAMPLE: begin
          if (cnt_end) begin
            state_ff <= ACD_ST_TRIAL;
            bit_ff <= 3'd7;
            sar_ff <= 8'h80;
            cnt_ff <= trial_len;
          end else begin
            cnt_ff <= cnt_ff - 6'd1;
          end
        end
        ACD_ST_TRIAL: begin
          if (cnt_end) begin
            if (bit_ff == 3'd0) begin
              sar_ff <= sar_kept;
              state_ff <= ACD_ST_IDLE;
            end else begin
              sar_ff <= sar_next_try;
              bit_ff <= bit_ff - 3'd1;
              cnt_ff <= trial_len;
            end
          end else begin
            cnt_ff <= cnt_ff - 6'd1;
          end
        end
        default: begin
          state_ff <= ACD_ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************

  // mode: speed and channel, reserved bits are not stored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      speed_ff <= 1'(`ACD_MODE_RST >> `ACD_MODE_SPEED_BIT);
      chan_ff <= 3'(`ACD_MODE_RST);
    end else if (wr_mode) begin
      speed_ff <= req.wdata[`ACD_MODE_SPEED_BIT];
      chan_ff <= req.wdata[2:0];
    end
  end

  // start flag: set by software, cleared by completion or abort
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_flag_ff <= 1'(`ACD_START_RST >> `ACD_START_FLAG_BIT);
    end else if (start_go) begin
      start_flag_ff <= 1'b1;
    end else if (abort_go | conv_done) begin
      start_flag_ff <= 1'b0;
    end
  end

  // result keeps no reset so a reset cannot disturb a stored value
  always_ff @(posedge clk_i) begin
    if (conv_done) begin
      result_ff <= sar_kept;
    end
  end

  // pin select and done enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pinsel_ff <= `ACD_PINSEL_RST;
      done_en_ff <= 1'b0;
    end else begin
      if (wr_pinsel) pinsel_ff <= req.wdata;
      if (wr_en) done_en_ff <= req.wdata[`ACD_IRQ_BIT];
    end
  end

  // done request: completion wins over a clearing write in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_req_ff <= 1'b0;
    end else if (conv_done) begin
      done_req_ff <= 1'b1;
    end else if (wr_req & ~req.wdata[`ACD_IRQ_BIT]) begin
      done_req_ff <= 1'b0;
    end
  end

  // ****************************************************************
  // read decode
  // ****************************************************************

  wire rd_mode = (req.rd_idx == `ACD_IDX_MODE);
  wire rd_result = (req.rd_idx == `ACD_IDX_RESULT);
  wire rd_start = (req.rd_idx == `ACD_IDX_START);
  wire rd_pinsel = (req.rd_idx == `ACD_IDX_PINSEL);
  wire rd_req = (req.rd_idx == `ACD_IDX_IRQ_REQ);
  wire rd_en = (req.rd_idx == `ACD_IDX_IRQ_EN);

  wire [7:0] mode_val = {speed_ff, `ACD_MODE_RSVD, chan_ff};
  wire [7:0] start_val = {start_flag_ff, `ACD_START_RSVD};
  // mid-conversion reads show the partial approximation
  wire [7:0] result_val = start_flag_ff ? sar_ff : result_ff;
  wire [7:0] req_val = {7'h00, done_req_ff};
  wire [7:0] en_val = {7'h00, done_en_ff};

  // the pin select register is write-only and reads back as zero
  assign rd_data = rd_mode ? mode_val :
                   rd_result ? result_val :
                   rd_start ? start_val :
                   rd_req ? req_val :
                   rd_en ? en_val : 8'h00;
  assign rd_err = ~(rd_mode | rd_result | rd_start | rd_pinsel | rd_req | rd_en);

  // ****************************************************************
  // analog side and outputs
  // ****************************************************************

  // everything leaves through a flop to keep the analog side glitch free
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan_out_ff <= 3'd0;
      sample_out_ff <= 1'b0;
      pin_out_ff <= 8'h00;
      busy_out_ff <= 1'b0;
      irq_out_ff <= 1'b0;
    end else begin
      chan_out_ff <= chan_ff;
      sample_out_ff <= in_sample & ~sample_end;
      pin_out_ff <= pinsel_ff;
      busy_out_ff <= start_flag_ff;
      irq_out_ff <= done_req_ff & done_en_ff;
    end
  end

  assign chan_sel_o = chan_out_ff;
  assign sample_hold_o = sample_out_ff;
  // ladder straight from the sar flop: an extra stage plus the synchroniser overruns a fast trial
  assign ladder_code_o = sar_ff;
  assign pin_analog_en_o = pin_out_ff;
  assign conv_busy_o = busy_out_ff;
  assign irq_o = irq_out_ff;

endmodule

`default_nettype wire

/* File: verilog/acd_consts.svh */
// constants for the converter control block: offsets, fields, resets, timing
`ifndef ACD_CONSTS_SVH
`define ACD_CONSTS_SVH

// register indices, byte address is four times the index
`define ACD_IDX_MODE 16'hffbc
`define ACD_IDX_RESULT 16'hffbd
`define ACD_IDX_START 16'hffbe
`define ACD_IDX_PINSEL 16'hffef
`define ACD_IDX_IRQ_REQ 16'hffc0
`define ACD_IDX_IRQ_EN 16'hffc1

// reset values
`define ACD_MODE_RST 8'h78
`define ACD_START_RST 8'h7f
`define ACD_PINSEL_RST 8'h00

// field positions and fixed patterns
`define ACD_MODE_SPEED_BIT 7
`define ACD_MODE_RSVD 4'hf
`define ACD_START_FLAG_BIT 7
`define ACD_START_RSVD 7'h7f
`define ACD_IRQ_BIT 0

// conversion timing in system clock cycles
`define ACD_PERIOD_SLOW 62
`define ACD_PERIOD_FAST 31
`define ACD_TRIAL_SLOW 6
`define ACD_TRIAL_FAST 3

// bus
`define ACD_AXI_ADDR_W 18
`define ACD_RESP_OKAY 2'b00
`define ACD_RESP_SLVERR 2'b10

`endif

/* File: verilog/acd_pkg.sv */
// types shared by the converter control block
`include "acd_consts.svh"

package acd_pkg;

  // conversion sequencer states
  typedef enum logic [1:0] {
    ACD_ST_IDLE = 2'b00,
    ACD_ST_SAMPLE = 2'b01,
    ACD_ST_TRIAL = 2'b10
  } acd_state_e;

  // one register access handed from the bus slave to the register file
  typedef struct packed {
    logic wr;
    logic [15:0] wr_idx;
    logic [7:0] wdata;
    logic wr_lane0;
    logic rd;
    logic [15:0] rd_idx;
  } acd_reg_req_s;

endpackage

/* File: verilog/acd_sync2.sv */
// two flip-flop synchroniser for levels entering from outside the clock domain
`timescale 1ns/1ps
`default_nettype none

module acd_sync2 #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= d_i;
      sync_ff <= meta_ff;
    end
  end

  assign q_o = sync_ff;

endmodule

`default_nettype wire

/* File: verilog/acd_axil_slave.sv */
// axi4-lite slave front end for the converter registers
`timescale 1ns/1ps
`default_nettype none

module acd_axil_slave
  import acd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [`ACD_AXI_ADDR_W-1:0] s_axil_awaddr_i,
  input wire logic s_axil_awvalid_i,
  output logic s_axil_awready_o,
  input wire logic [31:0] s_axil_wdata_i,
  input wire logic [3:0] s_axil_wstrb_i,
  input wire logic s_axil_wvalid_i,
  output logic s_axil_wready_o,
  output logic [1:0] s_axil_bresp_o,
  output logic s_axil_bvalid_o,
  input wire logic s_axil_bready_i,
  input wire logic [`ACD_AXI_ADDR_W-1:0] s_axil_araddr_i,
  input wire logic s_axil_arvalid_i,
  output logic s_axil_arready_o,
  output logic [31:0] s_axil_rdata_o,
  output logic [1:0] s_axil_rresp_o,
  output logic s_axil_rvalid_o,
  input wire logic s_axil_rready_i,
  output acd_pkg::acd_reg_req_s req_o,
  input wire logic wr_err_i,
  input wire logic [7:0] rd_data_i,
  input wire logic rd_err_i
);

  logic awready_ff, wready_ff, arready_ff, bvalid_ff, rvalid_ff;
  logic aw_hold_ff, w_hold_ff;
  logic [`ACD_AXI_ADDR_W-1:0] awaddr_ff;
  logic [7:0] wdata_ff;
  logic lane0_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [7:0] rdata_ff;

  // handshakes and the single write / single read in flight
  wire aw_take = s_axil_awvalid_i & awready_ff;
  wire w_take = s_axil_wvalid_i & wready_ff;
  wire ar_take = s_axil_arvalid_i & arready_ff;
  wire wr_fire = aw_hold_ff & w_hold_ff & ~bvalid_ff;
  wire nxt_aw_hold = (aw_hold_ff & ~wr_fire) | aw_take;
  wire nxt_w_hold = (w_hold_ff & ~wr_fire) | w_take;

  assign req_o = '{wr: wr_fire, wr_idx: awaddr_ff[`ACD_AXI_ADDR_W-1:2],
                   wdata: wdata_ff, wr_lane0: lane0_ff,
                   rd: ar_take, rd_idx: s_axil_araddr_i[`ACD_AXI_ADDR_W-1:2]};

  // address and data capture, either order
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= 8'h00;
      lane0_ff <= 1'b0;
    end else begin
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff <= nxt_w_hold;
      awready_ff <= ~nxt_aw_hold;
      wready_ff <= ~nxt_w_hold;
      if (aw_take) awaddr_ff <= s_axil_awaddr_i;
      if (w_take) begin
        wdata_ff <= s_axil_wdata_i[7:0];
        lane0_ff <= s_axil_wstrb_i[0];
      end
    end
  end

  // responses stand until the master takes them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= `ACD_RESP_OKAY;
      rvalid_ff <= 1'b0;
      rresp_ff <= `ACD_RESP_OKAY;
      rdata_ff <= 8'h00;
      arready_ff <= 1'b0;
    end else begin
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_err_i ? `ACD_RESP_SLVERR : `ACD_RESP_OKAY;
      end else if (s_axil_bready_i) begin
        bvalid_ff <= 1'b0;
      end
      if (ar_take) begin
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_data_i;
        rresp_ff <= rd_err_i ? `ACD_RESP_SLVERR : `ACD_RESP_OKAY;
      end else if (s_axil_rready_i) begin
        rvalid_ff <= 1'b0;
      end
      arready_ff <= ~(ar_take | (rvalid_ff & ~s_axil_rready_i));
    end
  end

  assign s_axil_awready_o = awready_ff;
  assign s_axil_wready_o = wready_ff;
  assign s_axil_bvalid_o = bvalid_ff;
  assign s_axil_bresp_o = bresp_ff;
  assign s_axil_arready_o = arready_ff;
  assign s_axil_rvalid_o = rvalid_ff;
  assign s_axil_rresp_o = rresp_ff;
  assign s_axil_rdata_o = {24'h000000, rdata_ff};

endmodule

`default_nettype wire

/* File: dv/acd_conv_ctrl_asserts.sv */
// concurrent checks on the converter control ports
`timescale 1ns/1ps
`default_nettype none
module acd_conv_ctrl_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic s_axil_arvalid_i,
  input wire logic s_axil_arready_o,
  input wire logic s_axil_rvalid_o,
  input wire logic s_axil_rready_i,
  input wire logic [31:0] s_axil_rdata_o,
  input wire logic s_axil_bvalid_o,
  input wire logic s_axil_bready_i,
  input wire logic [1:0] s_axil_bresp_o,
  input wire logic conv_busy_o,
  input wire logic sample_hold_o,
  input wire logic [7:0] ladder_code_o,
  input wire logic [7:0] pin_analog_en_o,
  input wire logic [2:0] chan_sel_o,
  input wire logic irq_o
);
  // ****
  // checks
  // ****
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [6:0] busy_len_ff;
  // busy cycles so far; a stuck flag runs this past the longest period
  always_ff @(posedge clk_i) begin
    if (rst_i || !conv_busy_o) begin
      busy_len_ff <= 7'd0;
    end else begin
      busy_len_ff <= busy_len_ff + 7'd1;
    end
  end
  sequence s_begin;
    $rose(conv_busy_o);
  endsequence
  sequence s_first_trial;
    ##[0:2] (ladder_code_o == 8'h80);
  endsequence
  property p_busy_max;
    conv_busy_o |-> busy_len_ff < 7'd62;
  endproperty
  property p_sh_start;
    s_begin |-> ##[0:1] sample_hold_o;
  endproperty
  property p_sh_busy;
    sample_hold_o |-> conv_busy_o || $past(conv_busy_o);
  endproperty
  property p_first_trial;
    $fell(sample_hold_o) && conv_busy_o |-> s_first_trial;
  endproperty
  property p_reset_out;
    $fell(rst_i) |-> pin_analog_en_o == 8'h00 && chan_sel_o == 3'd0 && !conv_busy_o && !irq_o;
  endproperty
  property p_b_hold;
    s_axil_bvalid_o && !s_axil_bready_i |=> s_axil_bvalid_o && $stable(s_axil_bresp_o);
  endproperty
  property p_r_hold;
    s_axil_rvalid_o && !s_axil_rready_i |=> s_axil_rvalid_o && $stable(s_axil_rdata_o);
  endproperty
  property p_r_upper;
    s_axil_rvalid_o |-> s_axil_rdata_o[31:8] == 24'h0;
  endproperty
  property p_r_answer;
    s_axil_arvalid_i && s_axil_arready_o |=> s_axil_rvalid_o;
  endproperty
  a_busy_max: assert property (p_busy_max)
    else $error("conversion longer than allowed");
  a_sh_start: assert property (p_sh_start)
    else $error("no sampling at conversion start");
  a_sh_busy: assert property (p_sh_busy)
    else $error("sampling outside a conversion");
  a_first_trial: assert property (p_first_trial)
    else $error("first trial is not the top bit");
  a_reset_out: assert property (p_reset_out)
    else $error("outputs not at reset values");
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped");
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped");
  a_r_upper: assert property (p_r_upper)
    else $error("read data upper bits set");
  a_r_answer: assert property (p_r_answer)
    else $error("read answer late");
endmodule
bind acd_conv_ctrl acd_conv_ctrl_chk i_chk (
  .clk_i, .rst_i, .s_axil_arvalid_i, .s_axil_arready_o, .s_axil_rvalid_o, .s_axil_rready_i,
  .s_axil_rdata_o, .s_axil_bvalid_o, .s_axil_bready_i, .s_axil_bresp_o, .conv_busy_o,
  .sample_hold_o, .ladder_code_o, .pin_analog_en_o, .chan_sel_o, .irq_o
);
`default_nettype wire

/* File: dv/acd_analog_model.sv */
// analog front end model: channel level compared with the ladder code
`timescale 1ns/1ps
`default_nettype none
module acd_analog_model (
  input wire logic clk_i,
  input wire logic [2:0] chan_sel_i,
  input wire logic [7:0] ladder_code_i,
  input wire logic [7:0] pin_analog_en_i,
  input wire logic [63:0] levels_i,
  output logic cmp_above_o
);
  logic toggle_ff = 1'b0;
  // a pin left digital gives no usable level, so it chatters
  always_ff @(posedge clk_i) begin
    toggle_ff <= ~toggle_ff;
  end
  // comparator settles within a trial; high when level >= code
  assign cmp_above_o = pin_analog_en_i[chan_sel_i] ?
    (levels_i[chan_sel_i*8 +: 8] >= ladder_code_i) : toggle_ff;
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
`include "acd_consts.svh"
module tb;
  import acd_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [17:0] awaddr = '0;
  logic [17:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [3:0] wstrb = 4'hf;
  logic [63:0] levels = '0;
  logic awready, wready, bvalid, arready, rvalid, cmp, sh, busy, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, seed;
  logic [7:0] ladder, pin_en;
  logic [2:0] chan;
  int bad_count = 0;
  int samples_checked = 0;
  int busy_len = 0;
  // ****
  // harness
  // ****
  acd_conv_ctrl i_acd_conv_ctrl (
    .clk_i(clk_i), .rst_i(rst_i), .s_axil_awaddr_i(awaddr), .s_axil_awvalid_i(awvalid),
    .s_axil_awready_o(awready), .s_axil_wdata_i(wdata), .s_axil_wstrb_i(wstrb),
    .s_axil_wvalid_i(wvalid), .s_axil_wready_o(wready), .s_axil_bresp_o(bresp),
    .s_axil_bvalid_o(bvalid), .s_axil_bready_i(bready), .s_axil_araddr_i(araddr),
    .s_axil_arvalid_i(arvalid), .s_axil_arready_o(arready), .s_axil_rdata_o(rdata),
    .s_axil_rresp_o(rresp), .s_axil_rvalid_o(rvalid), .s_axil_rready_i(rready),
    .cmp_above_i(cmp), .chan_sel_o(chan), .sample_hold_o(sh), .ladder_code_o(ladder),
    .pin_analog_en_o(pin_en), .conv_busy_o(busy), .irq_o(irq)
  );
  acd_analog_model i_acd_analog_model (
    .clk_i(clk_i), .chan_sel_i(chan), .ladder_code_i(ladder), .pin_analog_en_i(pin_en),
    .levels_i(levels), .cmp_above_o(cmp)
  );
  always #20 clk_i = ~clk_i;
  // flag cycles of the running conversion
  always @(posedge clk_i) if (busy) busy_len <= busy_len + 1;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic ck(input string s, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", s, exp, seen);
    end
  endtask
  // one edge of a bounded wait; running out ends the run
  task automatic tick(inout int n);
    @(posedge clk_i);
    n++;
    if (n > 300) begin
      ck("handshake timeout", 32'h1, 32'h0);
      wrap_up();
    end
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er_exp);
    int n;
    n = 0;
    @(posedge clk_i);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      tick(n);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    do tick(n); while (!bvalid);
    bready <= 1'b1;
    tick(n);
    ck("write resp", 32'(bresp), 32'(er_exp));
    bready <= 1'b0;
  endtask
  // late ready on purpose, so the slave has to hold its answer
  task automatic rd(input logic [15:0] idx, output logic [31:0] v, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    do tick(n); while (!arready);
    arvalid <= 1'b0;
    do tick(n); while (!rvalid);
    rready <= 1'b1;
    tick(n);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic er(input string s, input logic [15:0] idx, input logic [31:0] exp);
    logic [31:0] v;
    logic [1:0] r;
    rd(idx, v, r);
    ck(s, v, exp);
    ck(s, 32'(r), 32'h0);
  endtask
  // ****
  // scenarios
  // ****
  initial begin
    logic [31:0] v;
    logic [1:0] r;
    logic [7:0] lv;
    int n;
    seed = 32'h8703;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    er("mode", `ACD_IDX_MODE, 32'h78);
    er("start", `ACD_IDX_START, 32'h7f);
    er("pinsel", `ACD_IDX_PINSEL, 32'h00);
    rd(16'h0100, v, r);
    ck("unmapped resp", 32'(r), 32'h2);
    wr(`ACD_IDX_RESULT, 8'h5a, 2'b10);
    wr(`ACD_IDX_MODE, 8'h00, 2'b00);
    wr(`ACD_IDX_START, 8'h00, 2'b00);
    er("mode rsvd", `ACD_IDX_MODE, 32'h78);
    er("start rsvd", `ACD_IDX_START, 32'h7f);
    // a write without byte lane 0 answers okay and stores nothing
    wstrb <= 4'he;
    wr(`ACD_IDX_MODE, 8'h87, 2'b00);
    wstrb <= 4'hf;
    er("mode lane", `ACD_IDX_MODE, 32'h78);
    seed = xs(seed);
    wr(`ACD_IDX_PINSEL, seed[7:0], 2'b00);
    er("pinsel wo", `ACD_IDX_PINSEL, 32'h00);
    ck("pin enables", 32'(pin_en), 32'(seed[7:0]));
    $display("test registers done");
    for (int k = 0; k < 8; k++) begin
      seed = xs(seed);
      lv = (k == 0) ? 8'h00 : (k == 7) ? 8'hff : seed[7:0];
      levels[k*8 +: 8] <= lv;
      wr(`ACD_IDX_MODE, {k[0], 4'h0, k[2:0]}, 2'b00);
      wr(`ACD_IDX_PINSEL, 8'h01 << k, 2'b00);
      wr(`ACD_IDX_IRQ_EN, {7'h0, k != 7}, 2'b00);
      wr(`ACD_IDX_IRQ_REQ, 8'h00, 2'b00);
      busy_len = 0;
      wr(`ACD_IDX_START, 8'h80, 2'b00);
      n = 0;
      while (busy) tick(n);
      ck("period", 32'(busy_len), k[0] ? 32'd31 : 32'd62);
      er("result", `ACD_IDX_RESULT, 32'(lv));
      er("start idle", `ACD_IDX_START, 32'h7f);
      rd(`ACD_IDX_IRQ_REQ, v, r);
      ck("request", 32'(v[0]), 32'h1);
      ck("irq", 32'(irq), 32'(k != 7));
      ck("channel", 32'(chan), 32'(k));
      wr(`ACD_IDX_IRQ_REQ, 8'h00, 2'b00);
      er("result kept", `ACD_IDX_RESULT, 32'(lv));
      ck("irq cleared", 32'(irq), 32'h0);
    end
    $display("test conversions done");
    levels[63:56] <= 8'h3c;
    wr(`ACD_IDX_START, 8'h80, 2'b00);
    repeat (10) @(posedge clk_i);
    wr(`ACD_IDX_START, 8'h00, 2'b00);
    er("start abort", `ACD_IDX_START, 32'h7f);
    repeat (70) @(posedge clk_i);
    ck("busy abort", 32'(busy), 32'h0);
    er("result abort", `ACD_IDX_RESULT, 32'hff);
    rd(`ACD_IDX_IRQ_REQ, v, r);
    ck("request abort", 32'(v[0]), 32'h0);
    $display("test abort done");
    wr(`ACD_IDX_START, 8'h80, 2'b00);
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    er("result reset", `ACD_IDX_RESULT, 32'hff);
    er("mode reset", `ACD_IDX_MODE, 32'h78);
    er("start reset", `ACD_IDX_START, 32'h7f);
    $display("test reset done");
    wrap_up();
  end
endmodule
`default_nettype wire
